// File: ftoa_pkg.sv
// constants and carrier types for the flash trim and option access block
package ftoa_pkg;
  localparam int PAGE_BYTES = 512;
  localparam int ROWS_PER_PAGE = 8;
  localparam int ROW_BYTES = 64;
  localparam int SECTOR_BYTES_8K = 1024;
  localparam int SECTOR_BYTES_SMALL = 512;
  localparam int SIZE_8K = 8192;
  localparam int SIZE_1K = 1024;
  localparam int PAGES_8K = 16;
  localparam logic [15:0] PMEM_FIRST = 16'h0000;
  localparam logic [15:0] PMEM_LAST_8K = 16'h1FFF;
  localparam int OPTION_BYTES = 2;
  localparam int TRIM_BYTES = 32;
  localparam logic [7:0] TRIM_IDX_LAST = 8'h1F;
  localparam logic [6:0] TRIM_INFO_BASE = 7'h20;
  localparam int INFO_BYTES = 128;
  localparam int SERIAL_BYTES = 4;
  localparam logic [6:0] SERIAL_INFO_BASE = 7'h40;

  typedef enum logic [1:0] {
    FTOA_CMD_NONE,
    FTOA_CMD_PAGE_ERASE,
    FTOA_CMD_MASS_ERASE
  } ftoa_erase_t;

  // processor side request to the trim register pair
  typedef struct packed {
    logic addr_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] wdata;
  } ftoa_trim_req_t;

  // one info-page read through the program memory load path
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
  } ftoa_info_req_t;
endpackage

// File: ftoa_geometry.sv
// address geometry decoder for the program memory array
`timescale 1ns/100ps
`default_nettype none
module ftoa_geometry #(
  parameter int SIZE_BYTES = 8192
) (
  // address in
  input wire logic [15:0] addr,
  // decoded geometry
  output logic in_range,
  output logic [4:0] page,
  output logic [2:0] row,
  output logic [5:0] row_offset,
  output logic [3:0] sector,
  output logic is_option
);
  localparam int SECTOR = (SIZE_BYTES == ftoa_pkg::SIZE_8K) ?
    ftoa_pkg::SECTOR_BYTES_8K : ftoa_pkg::SECTOR_BYTES_SMALL;
  localparam int SECT_SH = $clog2(SECTOR);

  always_comb begin
    in_range = ({16'h0000, addr} < 32'(SIZE_BYTES));
    page = 5'(addr >> $clog2(ftoa_pkg::PAGE_BYTES));
    row = 3'(addr >> $clog2(ftoa_pkg::ROW_BYTES));
    row_offset = addr[5:0];
    sector = 4'(addr >> SECT_SH);
    is_option = ({16'h0000, addr} < 32'(ftoa_pkg::OPTION_BYTES));
  end
endmodule
`default_nettype wire

// File: ftoa_top.sv
// flash trim, option and information page access logic
// Function
// - array is built of 512 byte pages; a page is the smallest erase unit
// - each page holds 8 rows of 64 bytes
// - sectors are 1024 bytes on 8 KB size, 512 bytes otherwise
// - memory map follows size: 8 KB is 16 pages at 0000H-1FFFH
// - user option bits come from the lowest two program bytes
// - erasing page 0 also erases the option bits
// - factory trim survives erase; working copies revert on any reset
// - trim store has 32 bytes selected by index 00H-1FH
// - data register write replaces selected working trim byte
// - data register read returns selected working trim byte
// - trim indices reach only info locations 20-3F
// - calibration bytes are read by the program memory load instruction
// - four-byte serial number survives mass erase
`timescale 1ns/100ps
`default_nettype none
module ftoa_top #(
  parameter int SIZE_BYTES = 8192
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // trim register pair
  input wire ftoa_pkg::ftoa_trim_req_t trim_req,
  output logic [7:0] trim_rdata,
  output logic trim_rvalid,
  // program memory load of the information area
  input wire ftoa_pkg::ftoa_info_req_t info_req,
  output logic [7:0] info_rdata,
  output logic info_rvalid,
  // factory information page image
  input wire logic [8*ftoa_pkg::INFO_BYTES-1:0] info_image,
  // erase events from the flash controller
  input wire ftoa_pkg::ftoa_erase_t erase_cmd,
  input wire logic [15:0] erase_addr,
  // option byte load source and result, erased sector and serial number
  input wire logic [15:0] option_src,
  output logic [15:0] option_bits,
  output logic [3:0] erase_sector,
  output logic [31:0] serial_number
);
  // refuse array sizes that the geometry decoder cannot serve
  if (SIZE_BYTES < ftoa_pkg::SIZE_1K || SIZE_BYTES > ftoa_pkg::SIZE_8K ||
      (SIZE_BYTES & (SIZE_BYTES - 1)) != 0) begin : g_size_check
    $error("unsupported array size");
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] info_byte(input logic [6:0] a,
                                           input logic [8*ftoa_pkg::INFO_BYTES-1:0] img);
    info_byte = img[{a, 3'b000} +: 8];
  endfunction

  logic geo_in_range;
  logic [4:0] geo_page;
  logic [3:0] geo_sector;

  ftoa_geometry #(.SIZE_BYTES(SIZE_BYTES)) u_geo (
    .addr(erase_addr),
    .in_range(geo_in_range),
    .page(geo_page),
    .row(),
    .row_offset(),
    .sector(geo_sector),
    .is_option()
  );

  // ----------------------------------------
  // trim index and working store
  // ----------------------------------------
  logic [4:0] trim_idx_r;
  logic [7:0] trim_work_r [ftoa_pkg::TRIM_BYTES];
  logic trim_loaded_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      trim_idx_r <= 5'h00;
      trim_loaded_r <= 1'b0;
    end else if (trim_req.addr_wr) begin
      trim_idx_r <= trim_req.wdata[4:0];
      trim_loaded_r <= (trim_req.wdata <= ftoa_pkg::TRIM_IDX_LAST);
    end
  end

  // working copies reload from the factory bytes at 20-3F on every reset
  always_ff @(posedge clock) begin
    for (int i = 0; i < ftoa_pkg::TRIM_BYTES; i++) begin
      if (reset) begin
        trim_work_r[i] <= info_byte(ftoa_pkg::TRIM_INFO_BASE + 7'(i), info_image);
      end else if (trim_req.data_wr && trim_loaded_r && trim_idx_r == 5'(i)) begin
        trim_work_r[i] <= trim_req.wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      trim_rdata <= 8'h00;
      trim_rvalid <= 1'b0;
    end else begin
      trim_rvalid <= trim_req.data_rd;
      if (trim_req.data_rd)
        trim_rdata <= trim_loaded_r ? trim_work_r[trim_idx_r] : 8'h00;
    end
  end

  // ----------------------------------------
  // information area load path
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      info_rdata <= 8'h00;
      info_rvalid <= 1'b0;
    end else begin
      info_rvalid <= info_req.valid;
      if (info_req.valid)
        info_rdata <= info_byte(info_req.addr, info_image);
    end
  end

  // ----------------------------------------
  // option bits and erase effects
  // ----------------------------------------
  logic options_loaded_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      option_bits <= 16'hFFFF;
      options_loaded_r <= 1'b0;
      erase_sector <= 4'h0;
    end else begin
      if (!options_loaded_r) begin
        option_bits <= option_src;
        options_loaded_r <= 1'b1;
      end
      unique case (erase_cmd)
        ftoa_pkg::FTOA_CMD_PAGE_ERASE: begin
          if (geo_in_range) begin
            erase_sector <= geo_sector;
            if (geo_page == 5'h00)
              option_bits <= 16'hFFFF;
          end
        end
        ftoa_pkg::FTOA_CMD_MASS_ERASE: option_bits <= 16'hFFFF;
        default: ;
      endcase
    end
  end

  // serial number lives in the info page, untouched by any erase
  always_ff @(posedge clock) begin
    if (reset)
      serial_number <= 32'h0000_0000;
    else
      serial_number <= {info_byte(ftoa_pkg::SERIAL_INFO_BASE, info_image),
                        info_byte(ftoa_pkg::SERIAL_INFO_BASE + 7'h01, info_image),
                        info_byte(ftoa_pkg::SERIAL_INFO_BASE + 7'h02, info_image),
                        info_byte(ftoa_pkg::SERIAL_INFO_BASE + 7'h03, info_image)};
  end
endmodule
`default_nettype wire

// File: ftoa_props.sv
// port assertions for the flash trim and option access block
`timescale 1ns/100ps
`default_nettype none
module ftoa_props (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // watched ports
  input wire ftoa_pkg::ftoa_trim_req_t trim_req,
  input wire logic [7:0] trim_rdata,
  input wire logic trim_rvalid,
  input wire ftoa_pkg::ftoa_info_req_t info_req,
  input wire logic [7:0] info_rdata,
  input wire logic info_rvalid,
  input wire logic [8*ftoa_pkg::INFO_BYTES-1:0] info_image,
  input wire ftoa_pkg::ftoa_erase_t erase_cmd,
  input wire logic [15:0] erase_addr,
  input wire logic [15:0] option_src,
  input wire logic [15:0] option_bits,
  input wire logic [31:0] serial_number
);
  logic idx_bad_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      idx_bad_r <= 1'h1;
    end else if (trim_req.addr_wr) begin
      idx_bad_r <= trim_req.wdata > ftoa_pkg::TRIM_IDX_LAST;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence s_wr_rd;
    !idx_bad_r && trim_req.data_wr ##1 trim_req.data_rd && !trim_req.addr_wr;
  endsequence
  a_rd_answer: assert property (trim_req.data_rd |=> trim_rvalid)
    else $error("trim read not answered");
  a_rvalid_cause: assert property (trim_rvalid |-> $past(trim_req.data_rd))
    else $error("trim rvalid without read");
  a_wr_rd: assert property (s_wr_rd |=> trim_rdata == $past(trim_req.wdata, 2))
    else $error("trim read lost write");
  a_bad_idx: assert property (idx_bad_r && trim_req.data_rd |=> trim_rdata == 8'h00)
    else $error("bad index read not zero");
  a_info_rd: assert property (info_req.valid |=> info_rvalid
    && info_rdata == info_image[{$past(info_req.addr), 3'h0} +: 8])
    else $error("info read wrong");
  a_serial_kept: assert property (!$past(reset) |-> serial_number == {
    info_image[512 +: 8], info_image[520 +: 8], info_image[528 +: 8], info_image[536 +: 8]})
    else $error("serial number wrong");
  a_opt_erase: assert property ((erase_cmd == ftoa_pkg::FTOA_CMD_MASS_ERASE
    || (erase_cmd == ftoa_pkg::FTOA_CMD_PAGE_ERASE && erase_addr < 16'h0200))
    |=> option_bits == 16'hFFFF)
    else $error("option bits not erased");
  a_opt_load: assert property ($fell(reset) |=> option_bits == $past(option_src))
    else $error("option bits not loaded");
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the flash trim and option access block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock = 1'h0;
  logic reset = 1'h1;
  ftoa_pkg::ftoa_trim_req_t trim_req = '0;
  ftoa_pkg::ftoa_info_req_t info_req = '0;
  ftoa_pkg::ftoa_erase_t erase_cmd = ftoa_pkg::FTOA_CMD_NONE;
  logic [15:0] erase_addr = 16'h0000;
  logic [15:0] option_src = 16'hA55A;
  logic [8*ftoa_pkg::INFO_BYTES-1:0] info_image;
  logic [7:0] trim_rdata, info_rdata;
  logic trim_rvalid, info_rvalid;
  logic [15:0] option_bits;
  logic [31:0] serial_number;
  logic [3:0] erase_sector;
  int n_mismatch = 0;
  int comparisons = 0;
  initial begin
    forever #20 clock = ~clock;
  end
  ftoa_top ftoa_top_inst (.clock, .reset, .trim_req, .trim_rdata, .trim_rvalid, .info_req,
    .info_rdata, .info_rvalid, .info_image, .erase_cmd, .erase_addr, .option_src,
    .option_bits, .erase_sector, .serial_number);
  function automatic logic [7:0] img(int n);
    return 8'(n) ^ 8'hC3;
  endfunction
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", name, exp, got);
    end
  endtask
  // k is {addr_wr, data_wr, data_rd}; the request stands until the next call changes it
  task automatic req(logic [2:0] k, logic [7:0] d);
    trim_req = {k, d};
    @(negedge clock);
  endtask
  // read answer stands for one cycle only, so it is looked at right after the taking edge
  task automatic rd(logic [7:0] exp);
    req(3'h1, 8'h00);
    chk("trim_read", {1'h1, exp}, {trim_rvalid, trim_rdata});
    trim_req = '0;
    @(negedge clock);
  endtask
  task automatic ers(ftoa_pkg::ftoa_erase_t c, logic [15:0] a);
    erase_cmd = c;
    erase_addr = a;
    @(negedge clock);
    erase_cmd = ftoa_pkg::FTOA_CMD_NONE;
    @(negedge clock);
  endtask
  task automatic t_factory;
    for (int i = 0; i < 32; i++) begin
      req(3'h4, 8'(i));
      rd(img(i + 32));
    end
  endtask
  task automatic t_write;
    req(3'h4, 8'h1F);
    req(3'h2, 8'hAA);
    rd(8'hAA);
    rd(8'hAA);
    req(3'h4, 8'h20);
    req(3'h2, 8'h55);
    rd(8'h00);
    req(3'h4, 8'h00);
    rd(img(32));
  endtask
  task automatic t_info;
    for (int i = 0; i < 128; i += 63) begin
      info_req = {1'h1, 7'(i)};
      @(negedge clock);
      chk("info_read", {1'h1, img(i)}, {info_rvalid, info_rdata});
      info_req = '0;
      @(negedge clock);
    end
  endtask
  task automatic t_erase;
    chk("option_bits", option_src, option_bits);
    ers(ftoa_pkg::FTOA_CMD_PAGE_ERASE, 16'h1E00);
    chk("erase_sector", 32'h7, erase_sector);
    ers(ftoa_pkg::FTOA_CMD_PAGE_ERASE, 16'h2000);
    chk("erase_sector", 32'h7, erase_sector);
    ers(ftoa_pkg::FTOA_CMD_PAGE_ERASE, 16'h0200);
    chk("option_bits", option_src, option_bits);
    ers(ftoa_pkg::FTOA_CMD_PAGE_ERASE, 16'h01FF);
    chk("option_bits", 16'hFFFF, option_bits);
    req(3'h4, 8'h05);
    req(3'h2, 8'h99);
    trim_req = '0;
    reset = 1'h1;
    @(negedge clock);
    reset = 1'h0;
    @(negedge clock);
    chk("option_bits", option_src, option_bits);
    req(3'h4, 8'h05);
    rd(img(37));
    ers(ftoa_pkg::FTOA_CMD_MASS_ERASE, 16'h0000);
    chk("option_bits", 16'hFFFF, option_bits);
    chk("serial", {img(64), img(65), img(66), img(67)}, serial_number);
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    for (int i = 0; i < 128; i++) begin
      info_image[8*i +: 8] = img(i);
    end
    repeat (10) @(negedge clock);
    reset = 1'h0;
    @(negedge clock);
    t_factory;
    t_write;
    t_info;
    t_erase;
    end_sim;
  end
endmodule
bind ftoa_top ftoa_props ftoa_props_inst (.clock, .reset, .trim_req, .trim_rdata, .trim_rvalid,
  .info_req, .info_rdata, .info_rvalid, .info_image, .erase_cmd, .erase_addr, .option_src,
  .option_bits, .serial_number);
`default_nettype wire
